// *** verilog/bcp_pkg.sv ***
// Constants and types for the battery charge pocket controller
package bcp_pkg;

  // ---------------------------------------------------------------
  // Sizing and timing
  // ---------------------------------------------------------------
  localparam int POCKETS = 2;
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int FLASH_MS = 800;

  // ---------------------------------------------------------------
  // Thresholds: temperature in degC, voltage in 100 mV units
  // ---------------------------------------------------------------
  localparam logic [7:0] HOT_SET_C = 8'h28;
  localparam logic [7:0] HOT_CLR_C = 8'h1E;
  localparam logic [7:0] COLD_C = 8'h0A;
  localparam logic [7:0] LOW_V = 8'h3C;
  localparam logic [7:0] MAX_V = 8'h69;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] INTERVAL_OFS = 8'h04;
  localparam logic [7:0] LIMIT_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0] IRQ_EN_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam int IRQ_DONE_LSB = 0;
  localparam int IRQ_FAULT_LSB = POCKETS;
  localparam int STATE_FIELD_W = 4;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [15:0] INTERVAL_RST = 16'h03E8;
  localparam logic [7:0] LIMIT_RST = 8'h01;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PK_EMPTY, PK_WAIT, PK_FAST, PK_DONE} bcp_mode_t;

  typedef struct packed {
    logic present;
    logic tx;
    logic bad;
    logic shrt;
    logic [7:0] temp;
    logic [7:0] volt;
  } bcp_pin_t;

  typedef struct packed {
    logic fast;
    logic trickle;
    logic reform;
    logic ireduce;
    logic red;
    logic green;
  } bcp_drv_t;

  typedef struct packed {
    bcp_mode_t mode;
    logic hot;
    logic cold;
    logic fault_q;
    logic [7:0] last_temp;
  } bcp_pk_t;

  typedef struct packed {
    bcp_pin_t [POCKETS-1:0] sync1;
    bcp_pin_t [POCKETS-1:0] sync2;
    bcp_pk_t [POCKETS-1:0] pk;
    bcp_drv_t [POCKETS-1:0] drv;
    logic [15:0] tick_cnt;
    logic ms;
    logic [9:0] flash_cnt;
    logic flash_ph;
    logic [15:0] int_cnt;
    logic sample;
    logic ctrl_en;
    logic [15:0] interval;
    logic [7:0] limit;
    logic [2*POCKETS-1:0] irq_stat;
    logic [2*POCKETS-1:0] irq_en;
    logic irq;
    logic [31:0] rdata;
  } bcp_state_t;

endpackage

// *** verilog/bcp_charger.sv ***
// Multi-pocket charge sequencer, indicator driver and register slave
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps

module bcp_charger
  import bcp_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire bcp_pin_t [POCKETS-1:0] pin_i,
  output bcp_drv_t [POCKETS-1:0] drv_o
);

  bcp_state_t q;
  bcp_state_t next_q;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    bcp_pin_t pin;
    bcp_pk_t pk;
    bcp_drv_t d;
    logic t_ok;
    logic v_ok;
    logic fault;
    logic can_fast;
    logic [2*POCKETS-1:0] ev;
    pin = '0;
    pk = '0;
    d = '0;
    t_ok = 1'b0;
    v_ok = 1'b0;
    fault = 1'b0;
    can_fast = 1'b0;
    ev = '0;
    next_q = q;
    next_q.sync1 = pin_i;
    next_q.sync2 = q.sync1;

    // Millisecond tick
    next_q.ms = 1'b0;
    if (q.tick_cnt >= 16'(TICK_CYCLES_P - 1)) begin
      next_q.tick_cnt = '0;
      next_q.ms = 1'b1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 16'h0001;
    end

    // Flash phase
    if (q.ms) begin
      if (q.flash_cnt == 10'(FLASH_MS - 1)) begin
        next_q.flash_cnt = '0;
        next_q.flash_ph = ~q.flash_ph;
      end else begin
        next_q.flash_cnt = q.flash_cnt + 10'h001;
      end
    end

    // Temperature sample strobe
    next_q.sample = 1'b0;
    if (q.ms) begin
      if (q.int_cnt + 16'h0001 >= q.interval) begin
        next_q.int_cnt = '0;
        next_q.sample = 1'b1;
      end else begin
        next_q.int_cnt = q.int_cnt + 16'h0001;
      end
    end

    for (int p = 0; p < POCKETS; p++) begin
      pin = q.sync2[p];
      pk = q.pk[p];
      d = '0;
      if (!pin.present) begin
        pk.hot = 1'b0;
        pk.cold = 1'b0;
      end else begin
        if (pin.temp > HOT_SET_C) begin
          pk.hot = 1'b1;
        end else if (pin.temp < HOT_CLR_C) begin
          pk.hot = 1'b0;
        end
        if (pin.temp < COLD_C) begin
          pk.cold = 1'b1;
        end else if (pin.temp > COLD_C) begin
          pk.cold = 1'b0;
        end
      end
      t_ok = !pk.hot && !pk.cold;
      v_ok = pin.volt >= LOW_V;
      fault = pin.present && (pin.bad || pin.shrt || pk.hot || pk.cold);
      can_fast = t_ok && v_ok && q.ctrl_en && !pin.bad && !pin.shrt;

      if (!pin.present) begin
        pk.mode = PK_EMPTY;
      end else begin
        case (q.pk[p].mode)
          PK_EMPTY, PK_WAIT: begin
            if (can_fast) begin
              pk.mode = PK_FAST;
              pk.last_temp = pin.temp;
            end else begin
              pk.mode = PK_WAIT;
            end
          end
          PK_FAST: begin
            if (!can_fast) begin
              pk.mode = PK_WAIT;
            end else if (q.sample) begin
              if (pin.temp > q.pk[p].last_temp && pin.temp - q.pk[p].last_temp > q.limit) begin
                pk.mode = PK_DONE;
                ev[IRQ_DONE_LSB + p] = 1'b1;
              end
              pk.last_temp = pin.temp;
            end
          end
          PK_DONE: begin
            pk.mode = PK_DONE;
          end
          default: begin
            pk.mode = PK_EMPTY;
          end
        endcase
      end
      if (fault && !q.pk[p].fault_q) begin
        ev[IRQ_FAULT_LSB + p] = 1'b1;
      end
      pk.fault_q = fault;

      // Charge path drives
      d.fast = pk.mode == PK_FAST && !pin.tx;
      d.ireduce = d.fast && pin.volt >= MAX_V;
      d.reform = pin.present && !v_ok && !pin.shrt;
      d.trickle = pin.present && v_ok && !pin.shrt && pk.mode != PK_FAST;

      // Indicator, fault flash first
      if (!pin.present) begin
        d.red = 1'b1;
        d.green = 1'b1;
      end else if (pin.shrt) begin
        d.red = q.flash_ph;
        d.green = ~q.flash_ph;
      end else if (pin.bad) begin
        d.red = q.flash_ph;
        d.green = q.flash_ph;
      end else if (pk.hot) begin
        d.red = q.flash_ph;
      end else if (pk.cold) begin
        d.green = q.flash_ph;
      end else if (pk.mode == PK_DONE) begin
        d.green = 1'b1;
      end else begin
        d.red = 1'b1;
      end
      next_q.pk[p] = pk;
      next_q.drv[p] = d;
    end

    // Register writes
    if (wr_i) begin
      case (addr_i)
        CTRL_OFS: next_q.ctrl_en = wdata_i[CTRL_EN_BIT];
        INTERVAL_OFS: next_q.interval = wdata_i[15:0];
        LIMIT_OFS: next_q.limit = wdata_i[7:0];
        IRQ_EN_OFS: next_q.irq_en = wdata_i[2*POCKETS-1:0];
        default: begin
        end
      endcase
    end
    // Hardware set wins over software clear
    if (wr_i && addr_i == IRQ_CLR_OFS) begin
      next_q.irq_stat = (q.irq_stat & ~wdata_i[2*POCKETS-1:0]) | ev;
    end else begin
      next_q.irq_stat = q.irq_stat | ev;
    end
    next_q.irq = |(next_q.irq_stat & next_q.irq_en);

    // Register reads, one cycle later
    next_q.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        CTRL_OFS: next_q.rdata[CTRL_EN_BIT] = q.ctrl_en;
        INTERVAL_OFS: next_q.rdata[15:0] = q.interval;
        LIMIT_OFS: next_q.rdata[7:0] = q.limit;
        STATE_OFS: begin
          for (int p = 0; p < POCKETS; p++) begin
            next_q.rdata[p*STATE_FIELD_W +: STATE_FIELD_W] = {q.pk[p].hot, q.pk[p].cold, q.pk[p].mode};
          end
        end
        IRQ_STAT_OFS: next_q.rdata[2*POCKETS-1:0] = q.irq_stat;
        IRQ_EN_OFS: next_q.rdata[2*POCKETS-1:0] = q.irq_en;
        default: next_q.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.ctrl_en <= CTRL_EN_RST;
      q.interval <= INTERVAL_RST;
      q.limit <= LIMIT_RST;
      for (int p = 0; p < POCKETS; p++) begin
        q.drv[p].red <= 1'b1;
        q.drv[p].green <= 1'b1;
      end
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign irq_o = q.irq;
  assign drv_o = q.drv;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Every pocket checked, so each antecedent is reached by some pocket
  for (genvar g = 0; g < POCKETS; g++) begin : g_chk
    tx_suspend_a: assert property (q.drv[g].fast |-> !$past(q.sync2[g].tx))
      else $error("fast charge while transmitting");
    empty_amber_a: assert property (q.pk[g].mode == PK_EMPTY |-> q.drv[g].red && q.drv[g].green)
      else $error("empty pocket not amber");
    done_green_a: assert property ($rose(q.pk[g].mode == PK_DONE) |-> q.drv[g].green && !q.drv[g].red)
      else $error("charge complete not green");
    hot_inhibit_a: assert property ((q.pk[g].hot || q.pk[g].cold) |-> !q.drv[g].fast)
      else $error("fast charge while temperature inhibited");
    hot_release_a: assert property ($fell(q.pk[g].hot) && $past(q.sync2[g].present)
                                    |-> $past(q.sync2[g].temp) < HOT_CLR_C)
      else $error("hot inhibit released above clear level");
    reform_low_a: assert property (q.drv[g].reform |-> $past(q.sync2[g].volt) < LOW_V)
      else $error("re-form charge at good voltage");
    ireduce_a: assert property (q.drv[g].ireduce |-> q.drv[g].fast && $past(q.sync2[g].volt) >= MAX_V)
      else $error("current reduction without fast charge at limit");
    trickle_excl_a: assert property (q.drv[g].trickle |-> q.pk[g].mode != PK_FAST)
      else $error("trickle during fast charge");
  end
  flash_period_a: assert property ($changed(q.flash_ph)
                                   |-> q.flash_cnt == 10'h000 && $past(q.flash_cnt) == 10'(FLASH_MS - 1))
    else $error("flash phase changed off period");
  irq_level_a: assert property (irq_o == |(q.irq_stat & q.irq_en))
    else $error("interrupt level mismatch");

endmodule

// *** bench/bcp_battery.sv ***
// Battery or radio model driving the pocket sense inputs
`timescale 1ns/1ps
module bcp_battery
  import bcp_pkg::*;
(
  input wire logic clk_i,
  output bcp_pin_t [POCKETS-1:0] pin_o
);
  // ------
  // Sense drive
  // ------
  initial begin
    pin_o = '0;
  end

  // Flags are {present,tx,bad,shrt}; an empty pocket drives the sense lines with the inverted previous temp and volt
  task automatic put(input int k, input logic [3:0] f, input logic [7:0] tc, input logic [7:0] v);
    @(posedge clk_i);
    if (f[3]) begin
      pin_o[k] <= {f, tc, v};
    end else begin
      pin_o[k] <= {4'h0, ~pin_o[k].temp, ~pin_o[k].volt};
    end
  endtask
endmodule

// *** bench/bcp_charger_tb.sv ***
// Self-checking testbench for the battery charge pocket controller
`timescale 1ns/1ps
module bcp_charger_tb
  import bcp_pkg::*;
;
  localparam int TK = 4;
  localparam int FL = FLASH_MS * TK;
  logic clk_i;
  logic resetn_i;
  logic wr_i;
  logic rd_i;
  logic irq_o;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic [31:0] rdata_o;
  logic [31:0] rd_val;
  bcp_pin_t [POCKETS-1:0] pin_i;
  bcp_drv_t [POCKETS-1:0] drv_o;
  int n_errors;
  int cmp_count;
  int cyc = 0;

  bcp_charger #(.TICK_CYCLES_P(TK)) i_bcp_charger (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .pin_i(pin_i), .drv_o(drv_o));
  bcp_battery u_bat (.clk_i(clk_i), .pin_o(pin_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ------
  // Shared tasks
  // ------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_drv(input int p, input logic [5:0] e, input logic [5:0] m);
    cmp_count++;
    if ((drv_o[p] & m) !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, drv_o[p] & m, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  task automatic settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  // Counts cycles while the colour pair equals (stay=1) or differs from (stay=0) v
  task automatic run(input int p, input logic [1:0] v, input bit stay, output int n);
    n = 0;
    while ((({drv_o[p].red, drv_o[p].green} === v) == stay) && n < 4 * FL) begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask

  task automatic flash(input int p, input logic [1:0] on_v, input logic [1:0] off_v);
    int n;
    run(p, off_v, 1'b0, n);
    run(p, on_v, 1'b0, n);
    run(p, on_v, 1'b1, n);
    chk_word(32'(n), 32'(FL));
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    logic [7:0] ofs [6] = '{CTRL_OFS, INTERVAL_OFS, LIMIT_OFS, IRQ_EN_OFS, STATE_OFS, 8'h1C};
    logic [31:0] ev [6] = '{32'h1, 32'h3E8, 32'h1, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      chk_word(rd_val, ev[i]);
    end
    @(posedge clk_i);
    #1 chk_word(rdata_o, 32'h0);
    wr(STATE_OFS, 32'hFFFF);
    rd(STATE_OFS);
    chk_word(rd_val, 32'h0);
    chk_drv(0, 6'h03, 6'h3F);
    chk_drv(1, 6'h03, 6'h3F);
    $display("test regs done");
  endtask

  task automatic t_done();
    int n;
    wr(INTERVAL_OFS, 32'h2);
    wr(IRQ_EN_OFS, 32'h1);
    u_bat.put(0, 4'h8, 8'h19, 8'h50);
    settle();
    chk_drv(0, 6'h22, 6'h3F);
    chk_drv(1, 6'h03, 6'h3F);
    u_bat.put(0, 4'hC, 8'h19, 8'h50);
    settle();
    chk_drv(0, 6'h02, 6'h3F);
    u_bat.put(0, 4'h8, 8'h19, MAX_V);
    settle();
    chk_drv(0, 6'h26, 6'h3F);
    u_bat.put(0, 4'h8, 8'h1A, 8'h50);
    repeat (30) @(posedge clk_i);
    #1 chk_drv(0, 6'h22, 6'h3F);
    u_bat.put(0, 4'h8, 8'h1C, 8'h50);
    n = 0;
    while (drv_o[0].green !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk_drv(0, 6'h11, 6'h3F);
    chk_word(32'(irq_o), 32'h1);
    rd(STATE_OFS);
    chk_word(rd_val, 32'h3);
    wr(IRQ_CLR_OFS, 32'h1);
    settle();
    chk_word(32'(irq_o), 32'h0);
    u_bat.put(0, 4'h0, 8'h00, 8'h00);
    settle();
    chk_drv(0, 6'h03, 6'h3F);
    $display("test fast charge done");
  endtask

  task automatic t_temp();
    u_bat.put(1, 4'h8, 8'h2D, 8'h50);
    settle();
    chk_drv(1, 6'h10, 6'h3C);
    flash(1, 2'b10, 2'b00);
    u_bat.put(1, 4'h8, 8'h23, 8'h50);
    settle();
    chk_drv(1, 6'h10, 6'h3C);
    u_bat.put(1, 4'h8, 8'h1D, 8'h50);
    settle();
    chk_drv(1, 6'h22, 6'h3F);
    u_bat.put(1, 4'h8, 8'h05, 8'h50);
    settle();
    chk_drv(1, 6'h10, 6'h3C);
    flash(1, 2'b01, 2'b00);
    u_bat.put(1, 4'h8, COLD_C, 8'h50);
    settle();
    chk_drv(1, 6'h10, 6'h3C);
    u_bat.put(1, 4'h8, 8'h0B, 8'h50);
    settle();
    chk_drv(1, 6'h22, 6'h3F);
    $display("test temperature done");
  endtask

  task automatic t_fault();
    u_bat.put(1, 4'h9, 8'h19, 8'h50);
    settle();
    chk_drv(1, 6'h00, 6'h3C);
    flash(1, 2'b10, 2'b01);
    u_bat.put(1, 4'hA, 8'h19, 8'h50);
    settle();
    chk_drv(1, 6'h00, 6'h20);
    flash(1, 2'b11, 2'b00);
    rd(IRQ_STAT_OFS);
    chk_word(32'(rd_val[IRQ_FAULT_LSB + 1]), 32'h1);
    chk_word(32'(irq_o), 32'h0);
    wr(IRQ_CLR_OFS, 32'h1 << (IRQ_FAULT_LSB + 1));
    rd(IRQ_STAT_OFS);
    chk_word(32'(rd_val[IRQ_FAULT_LSB + 1]), 32'h0);
    u_bat.put(1, 4'h8, 8'h19, 8'h3B);
    settle();
    chk_drv(1, 6'h0A, 6'h2B);
    u_bat.put(1, 4'h8, 8'h19, LOW_V);
    settle();
    chk_drv(1, 6'h22, 6'h3F);
    wr(CTRL_OFS, 32'h0);
    settle();
    chk_drv(1, 6'h12, 6'h3F);
    rd(CTRL_OFS);
    chk_word(rd_val, 32'h0);
    wr(CTRL_OFS, 32'h1);
    settle();
    chk_drv(1, 6'h22, 6'h3F);
    $display("test faults done");
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end

  initial begin
    resetn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_done();
    t_temp();
    t_fault();
    wrap_up();
  end
endmodule
